/* core/ira_pkg.sv */
// ira_pkg: constants, register map and carrier types of the i/q route adder
// assumes one i/q sample per sys_clk and software access over apb
package ira_pkg;
  localparam int N_OUT = 4; // generation units 0..3, each owns an output
  localparam int N_SRC = 8; // units 4..7 reach an output only by a route
  localparam int N_RT = 3; // routes per output
  localparam int SW = 16; // sample width at the dac
  localparam int AW = 20; // sum width, headroom for four streams
  localparam int FRAC = 14; // factors are signed q1.14
  localparam int LAT_NS = 26; // added latency of the summation stages
  localparam int LAT_SMP = 52; // the same latency in samples, one per clock
  localparam int DLY_N = 16; // output delay line depth
  localparam int DLY_W = 4;
  localparam logic signed [15:0] AMP_RST = 16'sh4000; // unity
  localparam logic [15:0] PHS_RST = 16'h0000;
  localparam logic signed [15:0] COS_RST = 16'sh4000;
  localparam logic [2:0] SRC_X0 = 3'h4; // route m resets to unit 4+m
  localparam logic signed [AW-1:0] VMAX = 20'sh07fff;
  localparam logic signed [AW-1:0] VMIN = 20'shf8000;
  localparam logic signed [SW-1:0] SMAX = 16'sh7fff;
  localparam logic signed [SW-1:0] SMIN = 16'sh8000;
  // quarter wave of sine, 22.5 degree steps, q1.14
  localparam logic [4:0][15:0] QTAB = {16'h4000, 16'h3b21, 16'h2d41, 16'h187e, 16'h0000};
  // per output block at paddr[7:6]; offsets within the block
  localparam logic [5:0] OFS_CTRL = 6'h00; // bit0 combiner enable
  localparam logic [5:0] OFS_OVF = 6'h04; // overflow count, read only
  localparam logic [5:0] OFS_DLY = 6'h08; // output delay in samples
  localparam logic [5:0] OFS_RT = 6'h10; // route 0 config
  localparam logic [5:0] RT_STEP = 6'h0c; // route block stride
  localparam logic [5:0] OFS_AMP = 6'h04; // amplitude within route block
  localparam logic [5:0] OFS_PHS = 6'h08; // phase within route block
  localparam int SRC_LSB = 4; // route config: bit0 enable, [6:4] source
  localparam logic [11:0] OFS_IST = 12'h100; // interrupt status, w1c
  localparam logic [11:0] OFS_IMSK = 12'h104; // interrupt mask
  localparam int IST_REJ = 4; // [3:0] overflow, [7:4] rejected write

  typedef struct packed {
    logic signed [SW-1:0] i;
    logic signed [SW-1:0] q;
  } ira_iq_t;

  typedef struct packed {
    logic signed [AW-1:0] i;
    logic signed [AW-1:0] q;
  } ira_acc_t;

  typedef struct packed {
    logic en;
    logic [2:0] src;
    logic signed [15:0] amp;
    logic [15:0] phs;
    logic signed [15:0] cs;
    logic signed [15:0] sn;
  } ira_rt_t;

  typedef enum logic {
    AP_IDLE = 1'b0,
    AP_DONE = 1'b1
  } ira_ap_t;
endpackage

/* core/ira_top.sv */
// ira_top: per output i/q combiner with routed streams, delay and clamp
// assumes modulated streams arrive on sys_clk, one sample each clock
// Operation
// (RULE1) output is own i/q plus each enabled route's rotated, scaled source
// (RULE2) routes take modulated digital streams, before any conversion
// (RULE3) enabled combiner adds 52 samples (26 ns) of latency
// (RULE4) software enables the combiner on every channel sharing signals
// (RULE5) units 4-7 exist with no output, reach outputs only via routes
// (RULE6) units 0-3 each feed their own output as default stream
// (RULE7) output delay sits after the combiner, before the dac
// (RULE8) output-less units get no delay, clamp, counter or output logic
// (RULE9) channel enable and per route enable both gate routed streams
// (RULE10) source selector is a zero based unit index
// (RULE11) software keeps summed band within 1 GHz, equal center frequencies
// (RULE12) exactly three routes per output, each with full settings
// (RULE13) reject own index or duplicate source on one output
// (RULE14) count dac overflows; after any overflow clamp to full scale
// (RULE15) amplitude and phase held as 16-bit codes
// (RULE16) disabled route or combiner adds zero; disabled bypasses latency
// (RULE17) cosine and sine derived from phase code on phase write
`timescale 1ns/1ns
`default_nettype none
module ira_top (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ira_pkg::ira_iq_t [ira_pkg::N_SRC-1:0] src_iq,
  output logic [ira_pkg::N_OUT-1:0][2*ira_pkg::SW-1:0] dac_iq,
  output logic irq
);
  import ira_pkg::*;

  // all state of the block in one record, registered by a single process
  typedef struct packed {
    ira_ap_t ap;
    logic [31:0] prdata;
    logic perr;
    logic [N_OUT-1:0] en;
    logic [N_OUT-1:0][DLY_W-1:0] dly;
    ira_rt_t [N_OUT-1:0][N_RT-1:0] rt;
    logic [N_OUT-1:0][31:0] ovf_cnt;
    logic [N_OUT-1:0] seen;
    logic [7:0] ist;
    logic [7:0] imsk;
    logic irq;
    ira_acc_t [N_OUT-1:0][LAT_SMP-1:0] lat;
    ira_acc_t [N_OUT-1:0][DLY_N-1:0] dl;
    ira_iq_t [N_OUT-1:0] dac;
  } ira_st_t;

  ira_st_t s_ff;
  ira_st_t nxt_s;
  // decode results, shared by the read mux and the write strobe
  logic [1:0] ch;
  logic [5:0] off;
  logic hit;
  logic rej;
  logic is_cfg;
  logic [31:0] rd;
  logic [1:0] rsel;
  logic [1:0] rk;
  logic [7:0] ev;
  // datapath scratch, reused for each output in turn
  ira_acc_t acc;
  ira_acc_t rot;
  ira_acc_t pre;
  ira_acc_t dout;
  logic ovf;

  // coarse sine, 16 steps per turn; a limitation traded for a tiny table
  function automatic logic signed [15:0] sinf(input logic [15:0] p);
    logic [3:0] x;
    logic [15:0] v;
    // only phase[15:12] counts; finer codes fall on the same entry
    x = p[15:12];
    v = x[2] ? QTAB[3'h4 - {1'b0, x[1:0]}] : QTAB[{1'b0, x[1:0]}];
    return x[3] ? -$signed(v) : $signed(v);
  endfunction

  // (RULE1) complex rotate then scale
  function automatic ira_acc_t rotf(input ira_iq_t x, input ira_rt_t r);
    logic signed [32:0] pi;
    logic signed [32:0] pq;
    logic signed [18:0] ti;
    logic signed [18:0] tq;
    logic signed [34:0] ui;
    logic signed [34:0] uq;
    ira_acc_t y;
    // rotation first, then amplitude, each product cut back by 14 bits
    pi = 33'(x.i * r.cs) - 33'(x.q * r.sn);
    pq = 33'(x.i * r.sn) + 33'(x.q * r.cs);
    ti = 19'(pi >>> FRAC);
    tq = 19'(pq >>> FRAC);
    ui = 35'(ti * r.amp);
    uq = 35'(tq * r.amp);
    y.i = AW'(ui >>> FRAC);
    y.q = AW'(uq >>> FRAC);
    return y;
  endfunction

  // saturate a wide sum to the dac's full scale
  function automatic logic signed [SW-1:0] clip(input logic signed [AW-1:0] v);
    if (v > VMAX) begin
      return SMAX;
    end else if (v < VMIN) begin
      return SMIN;
    end
    return v[SW-1:0];
  endfunction

  // address decode; channel blocks below 0x100, interrupt words above
  // unmapped words read zero and answer with pslverr
  always_comb begin
    ch = paddr[7:6];
    off = paddr[5:0];
    hit = 1'b0;
    is_cfg = 1'b0;
    rej = 1'b0;
    rd = 32'h0;
    rsel = 2'h0;
    rk = 2'h0;
    if (paddr == OFS_IST) begin
      hit = 1'b1;
      rd = {24'h0, s_ff.ist};
    end else if (paddr == OFS_IMSK) begin
      hit = 1'b1;
      rd = {24'h0, s_ff.imsk};
    end else if (paddr[11:8] == 4'h0) begin
      if (off == OFS_CTRL) begin
        hit = 1'b1;
        rd = {31'h0, s_ff.en[ch]};
      end else if (off == OFS_OVF) begin
        hit = 1'b1;
        rd = s_ff.ovf_cnt[ch];
      end else if (off == OFS_DLY) begin
        hit = 1'b1;
        rd = {28'h0, s_ff.dly[ch]};
      end else begin
        // (RULE12) three route blocks of config, amplitude, phase
        for (int m = 0; m < N_RT; m++) begin
          if (off == 6'(OFS_RT + m * RT_STEP)) begin
            hit = 1'b1;
            is_cfg = 1'b1;
            rsel = 2'(m);
            rd = {25'h0, s_ff.rt[ch][m].src, 3'h0, s_ff.rt[ch][m].en};
          end else if (off == 6'(OFS_RT + m * RT_STEP + OFS_AMP)) begin
            hit = 1'b1;
            rsel = 2'(m);
            rk = 2'h1;
            rd = {16'h0, s_ff.rt[ch][m].amp};
          end else if (off == 6'(OFS_RT + m * RT_STEP + OFS_PHS)) begin
            hit = 1'b1;
            rsel = 2'(m);
            rk = 2'h2;
            rd = {16'h0, s_ff.rt[ch][m].phs};
          end
        end
      end
    end
    // disabled routes count as well, so a later enable can never clash
    // (RULE13) own index or a source already used by another route
    if (is_cfg && pwrite) begin
      if (pwdata[SRC_LSB+2:SRC_LSB] == {1'b0, ch}) begin
        rej = 1'b1;
      end
      for (int m = 0; m < N_RT; m++) begin
        if (2'(m) != rsel && s_ff.rt[ch][m].src == pwdata[SRC_LSB+2:SRC_LSB]) begin
          rej = 1'b1;
        end
      end
    end
  end

  // next state: bus slave, datapath per output, interrupt flags
  always_comb begin
    nxt_s = s_ff;
    ev = 8'h0;
    acc = '0;
    rot = '0;
    pre = '0;
    dout = '0;
    ovf = 1'b0;
    // one wait state: data and error are registered before pready
    if (s_ff.ap == AP_IDLE) begin
      if (psel && penable) begin
        nxt_s.ap = AP_DONE;
        nxt_s.prdata = pwrite ? 32'h0 : rd;
        nxt_s.perr = !hit || rej;
      end
    end else begin
      nxt_s.ap = AP_IDLE;
      // the write lands at the pready edge, while the master still holds it
      if (pwrite && rej) begin
        ev[IST_REJ + ch] = 1'b1;
      end
      if (pwrite && !s_ff.perr) begin
        if (paddr == OFS_IST) begin
          nxt_s.ist = s_ff.ist & ~pwdata[7:0];
        end else if (paddr == OFS_IMSK) begin
          nxt_s.imsk = pwdata[7:0];
        end else if (off == OFS_CTRL) begin
          // (RULE9) combiner enable
          nxt_s.en[ch] = pwdata[0];
        end else if (off == OFS_DLY) begin
          nxt_s.dly[ch] = pwdata[DLY_W-1:0];
        end else if (is_cfg) begin
          // (RULE10) zero based source index
          nxt_s.rt[ch][rsel].en = pwdata[0];
          nxt_s.rt[ch][rsel].src = pwdata[SRC_LSB+2:SRC_LSB];
        end else if (rk == 2'h1) begin
          // (RULE15) 16-bit amplitude code
          nxt_s.rt[ch][rsel].amp = pwdata[15:0];
        end else if (rk == 2'h2) begin
          // (RULE17) trig values follow each phase write
          nxt_s.rt[ch][rsel].phs = pwdata[15:0];
          nxt_s.rt[ch][rsel].cs = sinf(pwdata[15:0] + 16'h4000);
          nxt_s.rt[ch][rsel].sn = sinf(pwdata[15:0]);
        end
      end
    end
    // (RULE2) modulated digital inputs
    // (RULE8) only the owning units get output side logic
    for (int o = 0; o < N_OUT; o++) begin
      // (RULE6) own unit is the default stream
      acc.i = AW'(src_iq[o].i);
      acc.q = AW'(src_iq[o].q);
      for (int m = 0; m < N_RT; m++) begin
        // (RULE16) gated routes add nothing
        if (s_ff.en[o] && s_ff.rt[o][m].en) begin
          // a route may pick any unit; its own index is refused on write
          // (RULE5) any of the eight units, 4-7 included
          rot = rotf(src_iq[s_ff.rt[o][m].src], s_ff.rt[o][m]);
          acc.i = acc.i + rot.i;
          acc.q = acc.q + rot.q;
        end
      end
      // the line always shifts, so an enable shows older sums at once
      // (RULE3) summation pipeline, bypassed when the combiner is off
      nxt_s.lat[o] = {s_ff.lat[o][LAT_SMP-2:0], acc};
      pre = s_ff.en[o] ? s_ff.lat[o][LAT_SMP-1] : acc;
      // a new delay applies at once and may repeat or skip samples
      // (RULE7) one delay for default and routed streams alike
      nxt_s.dl[o] = {s_ff.dl[o][DLY_N-2:0], pre};
      dout = (s_ff.dly[o] == '0) ? pre : s_ff.dl[o][s_ff.dly[o] - 1'b1];
      // (RULE14) overflow count and sticky clamp
      ovf = dout.i > VMAX || dout.i < VMIN || dout.q > VMAX || dout.q < VMIN;
      if (ovf) begin
        nxt_s.seen[o] = 1'b1;
        ev[o] = 1'b1;
        // the count sticks at all ones rather than wrapping to zero
        if (s_ff.ovf_cnt[o] != 32'hffffffff) begin
          nxt_s.ovf_cnt[o] = s_ff.ovf_cnt[o] + 32'h1;
        end
      end
      // the clamp latches on the first overflow and holds until reset
      if (s_ff.seen[o] || ovf) begin
        nxt_s.dac[o].i = clip(dout.i);
        nxt_s.dac[o].q = clip(dout.q);
      end else begin
        // before any overflow the value fits, so this drops only sign copies
        nxt_s.dac[o].i = dout.i[SW-1:0];
        nxt_s.dac[o].q = dout.q[SW-1:0];
      end
    end
    // events win over a clear in the same cycle
    nxt_s.ist = nxt_s.ist | ev;
    // irq follows the next status and mask, so it rises with its flag
    nxt_s.irq = |(nxt_s.ist & nxt_s.imsk);
  end

  // state register; routes reset to distinct extra units so none is illegal
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= '0;
      for (int o = 0; o < N_OUT; o++) begin
        for (int m = 0; m < N_RT; m++) begin
          s_ff.rt[o][m].src <= SRC_X0 + 3'(m);
          s_ff.rt[o][m].amp <= AMP_RST;
          // phase zero: cosine one, sine left at zero
          s_ff.rt[o][m].phs <= PHS_RST;
          s_ff.rt[o][m].cs <= COS_RST;
        end
      end
    end else begin
      s_ff <= nxt_s;
    end
  end

  // every output comes from the state register; pslverr is perr gated by pready
  assign prdata = s_ff.prdata;
  assign pready = (s_ff.ap == AP_DONE);
  assign pslverr = pready && s_ff.perr;
  assign dac_iq = s_ff.dac;
  assign irq = s_ff.irq;
endmodule // ira_top
`default_nettype wire

/* tb/ira_top_monitor.sv */
// ira_top_monitor: port level checks of the route adder
// assumes it is bound into ira_top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module ira_top_monitor (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire ira_pkg::ira_iq_t [ira_pkg::N_SRC-1:0] src_iq,
  input wire logic [ira_pkg::N_OUT-1:0][2*ira_pkg::SW-1:0] dac_iq,
  input wire logic irq
);
  import ira_pkg::*;
  logic [N_OUT-1:0] en_ff;
  logic [N_OUT-1:0][DLY_W-1:0] dl_ff;
  logic acc;
  logic wok;
  assign acc = psel && penable && pready;
  assign wok = acc && pwrite && !pslverr && paddr[11:8] == 4'h0;
  // shadow of enable and delay; a refused write must not move it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_ff <= '0;
      dl_ff <= '0;
    end else if (wok && paddr[5:0] == OFS_CTRL) begin
      en_ff[paddr[7:6]] <= pwdata[0];
    end else if (wok && paddr[5:0] == OFS_DLY) begin
      dl_ff[paddr[7:6]] <= pwdata[DLY_W-1:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_ready_wait: assert property (
    psel && penable && !pready |=> pready) else $error("pready late");
  a_ready_pulse: assert property (
    pready |=> !pready) else $error("pready too long");
  a_idle_quiet: assert property (
    !(psel && penable) |-> !pready && !pslverr) else $error("answer without access");
  a_err_ready: assert property (
    pslverr |-> pready) else $error("pslverr without pready");
  a_write_rdata: assert property (
    acc && pwrite |-> prdata == 32'h0) else $error("write returned data");
  a_unmapped_err: assert property (
    acc && paddr >= 12'h108 |-> pslverr) else $error("unmapped not refused");
  a_own_src: assert property (
    acc && pwrite && paddr[11:8] == 4'h0 && paddr[5:0] == OFS_RT
    && pwdata[6:4] == {1'b0, paddr[7:6]} |-> pslverr) else $error("own source kept");
  // an idle combiner with no delay passes the own stream in one sample
  for (genvar c = 0; c < N_OUT; c++) begin : g_pass
    a_off_passthru: assert property (
      !en_ff[c] && dl_ff[c] == '0 && $past(!en_ff[c] && dl_ff[c] == '0)
      |-> dac_iq[c] == $past(src_iq[c])) else $error("bypass path wrong");
  end
  c_refused: cover property (pslverr);
  c_irq: cover property (irq);
  c_routed: cover property (en_ff[0] && dac_iq[0] != '0);
endmodule // ira_top_monitor
bind ira_top ira_top_monitor u_mon (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .src_iq(src_iq), .dac_iq(dac_iq), .irq(irq));
`default_nettype wire

/* tb/ira_dac_model.sv */
// ira_dac_model: converter stand-in at the far side of the adder
// assumes one registered word per output on every sys_clk
`timescale 1ns/1ns
`default_nettype none
module ira_dac_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [ira_pkg::N_OUT-1:0][2*ira_pkg::SW-1:0] dac_iq,
  output logic [ira_pkg::N_OUT-1:0][2*ira_pkg::SW-1:0] conv_ff
);
  import ira_pkg::*;
  // digital words converted
  // no back pressure: a converter never stalls the stream
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_ff <= '0;
    end else begin
      conv_ff <= dac_iq;
    end
  end
endmodule // ira_dac_model
`default_nettype wire

/* tb/ira_top_tb.sv */
// ira_top_tb: self-checking bench with an integer model of the adder
// assumes the monitor is bound and the dac model is compiled
`timescale 1ns/1ns
`default_nettype none
module ira_top_tb;
  import ira_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  ira_iq_t [N_SRC-1:0] src_iq = '0;
  logic [N_OUT-1:0][2*SW-1:0] dac_iq;
  ira_iq_t [N_SRC-1:0] h[$];
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int ce[4], dl[4], re[4][3], rs[4][3], ra[4][3], ph[4][3], pc[4][3];
  logic [N_OUT-1:0][2*SW-1:0] conv;
  ira_top uut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_iq(src_iq), .dac_iq(dac_iq), .irq(irq));
  ira_dac_model u_dac (.sys_clk(sys_clk), .arst_n(arst_n), .dac_iq(dac_iq), .conv_ff(conv));
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("Error %0t exp %h got %h", $time, e, g);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
    chk({31'h0, er}, {31'h0, ee});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0, r, er);
    chk(r, e);
  endtask
  function automatic logic [11:0] rt(input int c, m);
    return 12'(c * 64 + 16 + m * 12);
  endfunction
  // sixteen steps per turn of sine, folded from the shared quarter-wave table
  function automatic int tsin(input int p);
    int x;
    int v;
    x = (p >> 12) & 15;
    v = (x & 4) != 0 ? int'(QTAB[4 - (x & 3)]) : int'(QTAB[x & 3]);
    return x >= 8 ? -v : v;
  endfunction
  // route setup; the model keeps the table's cosine and sine of the phase
  task automatic cfg(input int c, m, en, src, input logic [15:0] amp, p);
    wr(rt(c, m) + 12'h4, {16'h0, amp}, 1'b0);
    wr(rt(c, m) + 12'h8, {16'h0, p}, 1'b0);
    wr(rt(c, m), 32'(en + src * 16), 1'b0);
    re[c][m] = en;
    rs[c][m] = src;
    ra[c][m] = $signed(amp);
    ph[c][m] = tsin(p);
    pc[c][m] = tsin(p + 16384);
  endtask
  task automatic ctl(input int c, en);
    wr(12'(c * 64), 32'(en), 1'b0);
    ce[c] = en;
  endtask
  function automatic logic [31:0] ex(input int c, input ira_iq_t [N_SRC-1:0] s);
    int i, q, ri, rq, k;
    i = s[c].i;
    q = s[c].q;
    for (int m = 0; m < N_RT; m++) begin
      k = rs[c][m];
      ri = (s[k].i * pc[c][m] - s[k].q * ph[c][m]) >>> FRAC;
      rq = (s[k].i * ph[c][m] + s[k].q * pc[c][m]) >>> FRAC;
      if (ce[c] != 0 && re[c][m] != 0) begin
        i += (ri * ra[c][m]) >>> FRAC;
        q += (rq * ra[c][m]) >>> FRAC;
      end
    end
    i = i > 32767 ? 32767 : (i < -32768 ? -32768 : i);
    q = q > 32767 ? 32767 : (q < -32768 ? -32768 : q);
    return {i[15:0], q[15:0]};
  endfunction
  // random streams in, output c compared with the model after its latency
  task automatic run(input int c, n, input bit big);
    ira_iq_t [N_SRC-1:0] s;
    int lat;
    lat = (ce[c] != 0 ? LAT_SMP + 1 : 1) + dl[c];
    h.delete();
    for (int t = 0; t < n + lat; t++) begin
      @(posedge sys_clk);
      // small baseband words, so the sum stays in band; big puts 0x7000 on i of units 0 and 1
      for (int u = 0; u < N_SRC; u++) begin
        s[u].i = (big && u < 2) ? 16'h7000 : 16'($urandom_range(8191) - 4096);
        s[u].q = 16'($urandom_range(8191) - 4096);
      end
      src_iq <= s;
      h.push_back(s);
      #1;
      if (t >= lat) chk(dac_iq[c], ex(c, h[t - lat]));
      if (t > lat) chk(conv[c], ex(c, h[t - lat - 1]));
    end
    @(posedge sys_clk);
  endtask
  initial begin
    logic [31:0] r;
    logic er;
    void'($urandom(32'h5e28));
    for (int c = 0; c < 4; c++) begin
      for (int m = 0; m < 3; m++) begin
        rs[c][m] = 4 + m;
        pc[c][m] = 16384;
      end
    end
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    for (int m = 0; m < N_RT; m++) begin
      rd(rt(0, m), 32'(64 + m * 16));
      rd(rt(0, m) + 12'h4, 32'h4000);
    end
    rd(12'h004, 32'h0);
    $display("reset test done");
    wr(rt(1, 0), 32'h11, 1'b1);
    wr(rt(1, 1), 32'h41, 1'b1);
    wr(12'h00c, 32'h1, 1'b1);
    wr(12'h200, 32'h1, 1'b1);
    rd(12'h200, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IMSK, 32'hff, 1'b0);
    rd(OFS_IST, 32'h20);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IST, 32'h20, 1'b0);
    rd(OFS_IST, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("reject test done");
    run(0, 30, 1'b0);
    run(2, 30, 1'b0);
    cfg(0, 1, 1, 3, 16'h4000, 16'h0000);
    cfg(0, 0, 1, 5, 16'h2000, 16'h4000);
    cfg(0, 2, 1, 7, 16'h4000, 16'ha000);
    rd(rt(0, 2) + 12'h8, 32'h0000a000);
    ctl(3, 1);
    ctl(0, 1);
    run(0, 60, 1'b0);
    wr(12'h008, 32'h3, 1'b0);
    rd(12'h008, 32'h3);
    dl[0] = 3;
    run(0, 40, 1'b0);
    ctl(0, 0);
    run(0, 30, 1'b0);
    $display("route test done");
    cfg(1, 0, 1, 0, 16'h4000, 16'h0000);
    ctl(1, 1);
    run(1, 20, 1'b1);
    rd(OFS_IST, 32'h2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, 12'h044, 32'h0, r, er);
    chk({31'h0, r != 32'h0}, 32'h1);
    $display("overflow test done");
    give_verdict();
  end
endmodule // ira_top_tb
`default_nettype wire
